// ### logic/mrp_defines.vh
// constants for the mode register programming controller
`ifndef MRP_DEFINES_VH
`define MRP_DEFINES_VH
// command pin codes {cs_n, ras_n, cas_n, we_n}
`define MRP_CMD_NOP 4'h7
`define MRP_CMD_MRS 4'h0
`define MRP_CMD_DES 4'hF
// bank address codes of the mode registers
`define MRP_BA_MR0 3'h0
`define MRP_BA_MR1 3'h1
// operating mode register field positions
`define MRP_BL_LSB 0
`define MRP_BL_MSB 1
`define MRP_BT_BIT 3
`define MRP_TM_BIT 7
`define MRP_DLLRST_BIT 8
`define MRP_PPD_BIT 12
// burst length codes
`define MRP_BL_FIX8 2'h0
`define MRP_BL_OTF 2'h1
`define MRP_BL_FIX4 2'h2
// default timings in link clock cycles
`define MRP_TMRD_CK 4
`define MRP_TMOD_CK 12
// width of link-clock cycle counters
`define MRP_CNT_W 8
`endif

// ### logic/mrp_sync.v
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module mrp_sync
(
   input wire ref_clk,
   input wire rst,
   input wire clk_en,
   input wire din,
   output reg dout
);
   reg meta;
   // first stage feeds only the second
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= 1'b0;
         dout <= 1'b0;
      end
      else if (clk_en)
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// ### logic/mrp_gap_timer.v
// down counter of link clock rising edges for one command spacing
`timescale 1ns/1ps
`include "mrp_defines.vh"
module mrp_gap_timer
#(
   parameter W = `MRP_CNT_W
)
(
   input wire ref_clk,
   input wire rst,
   input wire clk_en,
   input wire load,
   input wire [W-1:0] load_val,
   input wire tick,
   output wire done
);
   reg [W-1:0] cnt;
   // load on a mode set, count down on each link rising edge
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cnt <= {W{1'b0}};
      else if (clk_en)
      begin
         if (load)
            cnt <= load_val;
         else if (tick && cnt != {W{1'b0}})
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign done = (cnt == {W{1'b0}});
endmodule

// ### logic/mrp_ctrl.v
// controller that programs the operating mode register over the command pins
//
// Functional notes
// R1: mode registers change only via mode set
// R2: host writes every register after reset
// R3: every field of register driven each write
// R4: mode set keeps array data intact
// R5: hold tMRD between two mode sets
// R6: hold tMOD before other commands
// R7: mode set only when device idle
// R8: all command pins and banks low; ba here carries mrs_sel, so it is low for MR0 only
// R9: bit A3 picks sequential or interleaved
// R10: bits A0-A1 choose burst length mode
// R11: A12 picks chop or eight per command
// R12: eight-beat read order from start column
// R13: chop read uses group of four
// R14: write order fixed, column bit two chops
// R15: fixed chop writes start two earlier
// R16: read latency is additive plus CAS
// R17: keep test mode bit A7 clear
// R18: DLL reset bit clears itself
// R19: wait tDLLK after DLL reset; other commands here wait only tMOD
// R20: write recovery at least tWR over tCK
// R21: A12 selects precharge power-down exit
// R22: bank address selects target register
// R23: A12 chop, A10 auto-precharge per access
`timescale 1ns/1ps
`include "mrp_defines.vh"
module mrp_ctrl
#(
   parameter TMRD_CK = `MRP_TMRD_CK,
   parameter TMOD_CK = `MRP_TMOD_CK
)
(
   input wire ref_clk,
   input wire rst,
   input wire clk_en,
   input wire link_ck,
   input wire dev_idle,
   input wire mrs_req,
   input wire [2:0] mrs_sel,
   input wire [12:0] mrs_val,
   input wire other_req,
   input wire [3:0] other_cmd,
   input wire [2:0] other_ba,
   input wire [12:0] other_addr,
   output reg mrs_ack,
   output reg other_ack,
   output reg mrs_err,
   output reg [12:0] op_mode,
   output reg op_mode_valid,
   output reg cs_n,
   output reg ras_n,
   output reg cas_n,
   output reg we_n,
   output reg [2:0] ba,
   output reg [12:0] addr
);
   // ---------------------------------------------------------------
   // state codes
   // ---------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_ISSUE = 2'h1;
   localparam ST_HOLD = 2'h2;
   localparam [`MRP_CNT_W-1:0] MRD_VAL = TMRD_CK;
   localparam [`MRP_CNT_W-1:0] MOD_VAL = TMOD_CK;

   // ---------------------------------------------------------------
   // link clock and device idle sampling
   // ---------------------------------------------------------------
   wire ck_s;
   wire idle_s;
   reg ck_d;
   wire ck_rise;
   mrp_sync u_ck_sync
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .din(link_ck),
      .dout(ck_s)
   );
   mrp_sync u_idle_sync
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .din(dev_idle),
      .dout(idle_s)
   );
   // edge finder on the synchronised link clock
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ck_d <= 1'b0;
      else if (clk_en)
         ck_d <= ck_s;
   end
   assign ck_rise = ck_s & ~ck_d;

   // ---------------------------------------------------------------
   // command spacing timers
   // ---------------------------------------------------------------
   reg [1:0] st;
   reg [1:0] next_st;
   reg load_t;
   wire mrd_done;
   wire mod_done;
   mrp_gap_timer u_mrd
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .load(load_t),
      .load_val(MRD_VAL),
      .tick(ck_rise),
      .done(mrd_done)
   );
   mrp_gap_timer u_mod
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .load(load_t),
      .load_val(MOD_VAL),
      .tick(ck_rise),
      .done(mod_done)
   );

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   reg is_mrs;
   reg is_nop;
   reg [12:0] sane_val;
   // test mode bit forced clear, reserved burst code refused
   always @*
   begin
      is_mrs = (other_cmd == `MRP_CMD_MRS);
      is_nop = (other_cmd == `MRP_CMD_NOP) || (other_cmd == `MRP_CMD_DES);
      sane_val = mrs_val;
      if (mrs_sel == `MRP_BA_MR0)
         sane_val[`MRP_TM_BIT] = 1'b0; // R17
   end
   wire mr0_bad = (mrs_sel == `MRP_BA_MR0) &&
      (mrs_val[`MRP_BL_MSB:`MRP_BL_LSB] == 2'h3); // R10
   // mode set waits for tMRD and an idle device
   wire mrs_ok = mrd_done && idle_s; // R5 R7
   // ordinary commands wait for tMOD; NOP and deselect never wait
   wire oth_ok = mod_done || is_nop; // R6

   // next state
   always @*
   begin
      next_st = st;
      case (st)
         ST_IDLE:
         begin
            if (ck_rise)
               next_st = ST_ISSUE;
         end
         ST_ISSUE:
            next_st = ST_HOLD;
         ST_HOLD:
            next_st = ST_IDLE; // one command per link period
         default:
            next_st = ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // command issue: one command per link cycle, NOP otherwise
   // ---------------------------------------------------------------
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= ST_IDLE;
         load_t <= 1'b0;
         mrs_ack <= 1'b0;
         other_ack <= 1'b0;
         mrs_err <= 1'b0;
         op_mode <= 13'h0000;
         op_mode_valid <= 1'b0;
         {cs_n, ras_n, cas_n, we_n} <= `MRP_CMD_NOP;
         ba <= 3'h0;
         addr <= 13'h0000;
      end
      else if (clk_en)
      begin
         st <= next_st;
         load_t <= 1'b0;
         mrs_ack <= 1'b0;
         other_ack <= 1'b0;
         mrs_err <= 1'b0;
         // pins change just after a link rising edge, sampled at the next
         if (st == ST_IDLE && ck_rise)
         begin
            {cs_n, ras_n, cas_n, we_n} <= `MRP_CMD_NOP;
            if (mrs_req && mr0_bad)
               mrs_err <= 1'b1;
            else if (mrs_req && mrs_ok)
            begin
               // full word on every write, bank picks register
               {cs_n, ras_n, cas_n, we_n} <= `MRP_CMD_MRS; // R1 R8
               ba <= mrs_sel; // R22
               addr <= sane_val; // R3
               load_t <= 1'b1;
               mrs_ack <= 1'b1;
               if (mrs_sel == `MRP_BA_MR0)
               begin
                  // shadow keeps burst, latency and exit fields; the
                  // device clears its DLL reset bit by itself
                  op_mode <= sane_val; // R4 R9 R10 R12 R13 R14 R15 R16
                  // write recovery and exit mode fields kept as given
                  // R20 R21
                  op_mode[`MRP_DLLRST_BIT] <= 1'b0; // R18
                  op_mode_valid <= 1'b1; // R2
               end
            end
            else if (other_req && !is_mrs && oth_ok)
            begin
               // A12 and A10 pass through for chop and auto-precharge
               {cs_n, ras_n, cas_n, we_n} <= other_cmd; // R11 R23
               ba <= other_ba;
               addr <= other_addr;
               other_ack <= 1'b1;
            end
         end
      end
   end
endmodule

// ### tb/mrp_ctrl_sva.sv
// assertions on the mode register programming controller ports
`timescale 1ns/1ps
module mrp_ctrl_sva
#(
   parameter TMRD_CK = 4,
   parameter TMOD_CK = 12
)
(
   input wire ref_clk,
   input wire rst,
   input wire mrs_ack,
   input wire mrs_err,
   input wire other_ack,
   input wire [2:0] mrs_sel,
   input wire [3:0] other_cmd,
   input wire [12:0] other_addr,
   input wire [12:0] op_mode,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [2:0] ba,
   input wire [12:0] addr
);
   // command pins as one code
   wire [3:0] pins = {cs_n, ras_n, cas_n, we_n};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_mrs_pins: assert property (mrs_ack |-> pins == 4'h0 && ba == mrs_sel)
      else $error("mode set pins wrong");
   a_pins_stand: assert property (mrs_ack |=> (pins == 4'h0) [*8])
      else $error("mode set pins not held");
   a_mode_copy: assert property (mrs_ack && ba == 3'h0 |->
      op_mode == (addr & 13'h1E7F) && !addr[7])
      else $error("shadow differs from pins");
   a_shadow_bits: assert property (op_mode[8:7] == 2'h0)
      else $error("shadow test or dll bit set");
   a_err_quiet: assert property (mrs_err |-> !mrs_ack && $stable(op_mode))
      else $error("refused word took effect");
   a_mrs_spacing: assert property (mrs_ack |=> !mrs_ack [*8])
      else $error("mode sets too close");
   a_mod_spacing: assert property (mrs_ack |=> !other_ack [*8])
      else $error("command too soon after mode set");
   a_other_pins: assert property (other_ack |->
      pins == other_cmd && addr == other_addr)
      else $error("other command pins wrong");
endmodule
bind mrp_ctrl mrp_ctrl_sva #(.TMRD_CK(TMRD_CK), .TMOD_CK(TMOD_CK)) sva_u
   (.ref_clk(ref_clk), .rst(rst), .mrs_ack(mrs_ack), .mrs_err(mrs_err),
   .other_ack(other_ack), .mrs_sel(mrs_sel), .other_cmd(other_cmd),
   .other_addr(other_addr), .op_mode(op_mode), .cs_n(cs_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

// ### tb/mrp_dev_model.sv
// memory device model holding the mode registers
`timescale 1ns/1ps
module mrp_dev_model
#(
   parameter TMRD_CK = 2,
   parameter TMOD_CK = 2
)
(
   input wire link_ck,
   input wire dev_idle,
   input wire [3:0] cmd,
   input wire [2:0] ba,
   input wire [12:0] addr,
   output reg [12:0] mr0,
   output reg [31:0] viol
);
   reg [12:0] mr [0:3];
   integer gap = 99;
   initial viol = 0;
   // pins sampled on each link rise
   always @(posedge link_ck)
   begin
      gap = gap + 1;
      if (cmd == 4'h0)
      begin
         if (gap < TMRD_CK || !dev_idle) viol = viol + 1;
         mr[ba[1:0]] = addr;
         if (ba == 3'h0) mr0 = addr & 13'h1EFF;
         gap = 0;
      end
      else if (!cmd[3] && cmd != 4'h7 && gap < TMOD_CK) viol = viol + 1;
   end
endmodule

// ### tb/mrp_ctrl_tb.sv
// self-checking bench for the mode register programming controller
`timescale 1ns/1ps
module mrp_ctrl_tb;
   reg ref_clk = 0, rst = 1, link_ck = 0, dev_idle = 1;
   reg mrs_req = 0, other_req = 0;
   reg [2:0] mrs_sel = 0;
   reg [12:0] mrs_val = 0, v, pv;
   reg [3:0] other_cmd = 4'h7;
   wire mrs_ack, other_ack, mrs_err, valid, cs_n, ras_n, cas_n, we_n;
   wire [12:0] op_mode, addr, dev_mr0;
   wire [2:0] ba;
   wire [31:0] dev_viol;
   integer error_cnt = 0, n_tests = 0, i, n;
   always #2 ref_clk = ~ref_clk;
   always #24 link_ck = ~link_ck;
   mrp_ctrl #(.TMRD_CK(2), .TMOD_CK(2)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .clk_en(1'b1), .link_ck(link_ck), .dev_idle(dev_idle),
      .mrs_req(mrs_req), .mrs_sel(mrs_sel), .mrs_val(mrs_val),
      .other_req(other_req), .other_cmd(other_cmd), .other_ba(mrs_sel),
      .other_addr(mrs_val), .mrs_ack(mrs_ack), .other_ack(other_ack),
      .mrs_err(mrs_err), .op_mode(op_mode), .op_mode_valid(valid),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr));
   mrp_dev_model #(.TMRD_CK(2), .TMOD_CK(2)) model_u (.link_ck(link_ck),
      .dev_idle(dev_idle), .cmd({cs_n, ras_n, cas_n, we_n}), .ba(ba),
      .addr(addr), .mr0(dev_mr0), .viol(dev_viol));
   // compare and count
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // step n edges, then off the edge
   task wt(input integer c);
   begin
      repeat (c) @(posedge ref_clk);
      #1;
   end
   endtask
   // mode set request held until answered
   task mrs(input [2:0] s, input [12:0] val);
   begin
      wt(1);
      mrs_sel = s;
      mrs_val = val;
      mrs_req = 1;
      for (n = 0; n < 300 && mrs_ack !== 1'b1 && mrs_err !== 1'b1; n++) wt(1);
      mrs_req = 0;
      chk(n < 300, 1);
   end
   endtask
   // other command held until answered
   task oth(input [3:0] c);
   begin
      wt(1);
      other_cmd = c;
      other_req = 1;
      for (n = 0; n < 300 && other_ack !== 1'b1; n++) wt(1);
      other_req = 0;
      chk(n < 300, 1);
   end
   endtask
   // expected shadow: test and dll bits clear
   function [12:0] shadow(input [12:0] x);
      shadow = x & 13'h1E7F;
   endfunction
   task end_sim;
   begin
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   // watchdog
   initial
   begin
      #300000;
      error_cnt++;
      end_sim;
   end
   initial
   begin
      v = $urandom(32'hA7451FF1);
      wt(12);
      rst = 0;
      // all four registers written first
      for (i = 0; i < 4; i++)
      begin
         v = $urandom;
         v[1:0] = i % 3;
         v[7] = 0;
         mrs(3 - i, v);
         wt(16);
         chk(model_u.mr[3 - i], v);
      end
      chk(op_mode, shadow(v));
      chk(valid, 1);
      $display("test init done");
      // random operating modes, each followed at once by a command
      for (i = 0; i < 9; i++)
      begin
         v = $urandom;
         v[1:0] = i % 3;
         mrs(0, v);
         chk(op_mode, shadow(v));
         oth((i % 6) + 1);
         wt(16);
         chk(dev_mr0, v & 13'h1E7F);
      end
      $display("test modes done");
      // reserved burst code refused
      mrs(0, v | 13'h0003);
      chk(mrs_err, 1);
      chk(op_mode, shadow(v));
      $display("test reserved done");
      // busy device holds the mode set back
      dev_idle = 0;
      wt(8);
      pv = v;
      v = $urandom & 13'h1F7C;
      fork
         mrs(0, v);
         begin
            wt(100);
            chk(op_mode, shadow(pv));
            chk(dev_mr0, pv & 13'h1E7F);
            dev_idle = 1;
         end
      join
      chk(op_mode, shadow(v));
      wt(16);
      chk(dev_viol, 0);
      $display("test idle done");
      end_sim;
   end
endmodule
